/* File: design/power_mode_map.svh */
`ifndef POWER_MODE_MAP_SVH
`define POWER_MODE_MAP_SVH
`define ADDR_CONTROL 4'h0
`define ADDR_PROTECTION 4'h4
`define ADDR_STATUS 4'h8
`define RUN_SEL_NORMAL 2'h0
`define RUN_SEL_VLP 2'h2
`define STOP_SEL_NORMAL 3'h0
`define STOP_SEL_VLP 3'h2
`define CTRL_STOP_LSB 0
`define CTRL_RUN_LSB 5
`define CTRL_WAKE_BIT 7
`define PROT_ALLOW_BIT 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: design/power_mode_pkg.sv */
package power_mode_pkg;
  typedef enum logic [5:0] {
    st_run = 6'h01,
    st_wait = 6'h02,
    st_stop = 6'h04,
    st_very_low_power_run = 6'h08,
    st_very_low_power_wait = 6'h10,
    st_very_low_power_stop = 6'h20
  } mode_e;
endpackage

/* File: design/power_mode_transition_fsm.sv */
`include "power_mode_map.svh"
// Behaviour
// [RULE1] Sleep entry without deep-sleep in run moves to wait.
// [RULE2] Interrupt or reset returns wait or stop to run.
// [RULE3] Run select 00, stop select 000, deep sleep: run moves to stop.
// [RULE4] Software limits clocks before requesting very-low-power run.
// [RULE5] Allow bit 1 and run select 10 enters very-low-power run, even after reset.
// [RULE6] Run select 00, wake-to-run interrupt, or reset leaves very-low-power run.
// [RULE7] Sleep without deep-sleep in very-low-power run enters very-low-power wait.
// [RULE8] Wait interrupt goes run if wake bit 1, else very-low-power run.
// [RULE9] Very-low-power run, stop select 000/010, deep sleep enters very-low-power stop.
// [RULE10] Stop wake goes very-low-power run, or run if wake bit 1 or entered from run.
// [RULE11] Without wake-to-run bit, behave as if it were 0.
// [RULE12] Any reset returns to boot-configured default run state.
module power_mode_transition_fsm
  import power_mode_pkg::*;
#(
  parameter bit HAS_WAKE_TO_RUN = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_request,
  input wire logic deep_sleep_flag,
  input wire logic interrupt_pending,
  input wire logic boot_power_config,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [5:0] power_mode
);

  typedef struct packed {
    mode_e mode;
    logic stop_from_run;
    logic booted;
    logic [1:0] run_mode_select;
    logic [2:0] stop_mode_select;
    logic low_power_wake_to_run;
    logic allow_very_low_power;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic wake_bit;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    // [RULE11] Absent wake bit
    wake_bit = HAS_WAKE_TO_RUN & cur.low_power_wake_to_run;

    // One-shot boot load of low-power config after reset release
    if (!cur.booted) begin
      next_cur.booted = 1'b1;
      next_cur.allow_very_low_power = boot_power_config;
      next_cur.run_mode_select = boot_power_config ? `RUN_SEL_VLP : `RUN_SEL_NORMAL;
    end

    case (cur.mode)
      st_run: begin
        // [RULE5] Enter very-low-power run
        if (cur.allow_very_low_power && cur.run_mode_select == `RUN_SEL_VLP) begin
          next_cur.mode = st_very_low_power_run;
        end else if (sleep_request && !deep_sleep_flag) begin
          // [RULE1] Run to wait
          next_cur.mode = st_wait;
        end else if (sleep_request && deep_sleep_flag) begin
          // [RULE3] Run to stop
          if (cur.run_mode_select == `RUN_SEL_NORMAL &&
              cur.stop_mode_select == `STOP_SEL_NORMAL) begin
            next_cur.mode = st_stop;
          end else if (cur.allow_very_low_power &&
                       cur.stop_mode_select == `STOP_SEL_VLP) begin
            next_cur.mode = st_very_low_power_stop;
            next_cur.stop_from_run = 1'b1;
          end
        end
      end
      st_wait, st_stop: begin
        // [RULE2] Wake to run
        if (interrupt_pending) begin
          next_cur.mode = st_run;
        end
      end
      st_very_low_power_run: begin
        // [RULE6] Leave very-low-power run
        if (cur.run_mode_select == `RUN_SEL_NORMAL || (interrupt_pending && wake_bit)) begin
          next_cur.mode = st_run;
          next_cur.run_mode_select = `RUN_SEL_NORMAL;
        end else if (sleep_request && !deep_sleep_flag) begin
          // [RULE7] Enter very-low-power wait
          next_cur.mode = st_very_low_power_wait;
        end else if (sleep_request && deep_sleep_flag &&
                     (cur.stop_mode_select == `STOP_SEL_NORMAL ||
                      cur.stop_mode_select == `STOP_SEL_VLP)) begin
          // [RULE9] Enter very-low-power stop
          next_cur.mode = st_very_low_power_stop;
          next_cur.stop_from_run = 1'b0;
        end
      end
      st_very_low_power_wait: begin
        // [RULE8] Wait wake target
        if (interrupt_pending) begin
          next_cur.mode = wake_bit ? st_run : st_very_low_power_run;
          if (wake_bit) begin
            next_cur.run_mode_select = `RUN_SEL_NORMAL;
          end
        end
      end
      st_very_low_power_stop: begin
        // [RULE10] Stop wake target
        if (interrupt_pending) begin
          if (wake_bit || cur.stop_from_run) begin
            next_cur.mode = st_run;
            next_cur.run_mode_select = `RUN_SEL_NORMAL;
          end else begin
            next_cur.mode = st_very_low_power_run;
          end
        end
      end
      default: begin
        next_cur.mode = st_run;
      end
    endcase

    //////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && cur.awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
      next_cur.awready = 1'b0;
    end
    if (s_axi_wvalid && cur.wready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_lane0 = s_axi_wstrb[0];
      next_cur.wready = 1'b0;
    end
    if (cur.aw_held && cur.w_held && !cur.bvalid) begin
      next_cur.bvalid = 1'b1;
      next_cur.bresp = `RESP_OKAY;
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      case (cur.aw_addr)
        `ADDR_CONTROL: begin
          // A write only changes run select while running, so a stale write cannot jump states
          if (cur.w_lane0) begin
            next_cur.stop_mode_select = cur.w_data[`CTRL_STOP_LSB +: 3];
            next_cur.low_power_wake_to_run = cur.w_data[`CTRL_WAKE_BIT];
            if (cur.mode == st_run || cur.mode == st_very_low_power_run) begin
              next_cur.run_mode_select = cur.w_data[`CTRL_RUN_LSB +: 2];
            end
          end
        end
        `ADDR_PROTECTION: begin
          if (cur.w_lane0) begin
            next_cur.allow_very_low_power = cur.w_data[`PROT_ALLOW_BIT];
          end
        end
        `ADDR_STATUS: begin
        end
        default: begin
          next_cur.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready = 1'b1;
    end

    // AXI4-Lite read
    if (s_axi_arvalid && cur.arready) begin
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rresp = `RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `ADDR_CONTROL: begin
          next_cur.rdata[`CTRL_STOP_LSB +: 3] = cur.stop_mode_select;
          next_cur.rdata[`CTRL_RUN_LSB +: 2] = cur.run_mode_select;
          next_cur.rdata[`CTRL_WAKE_BIT] = cur.low_power_wake_to_run;
        end
        `ADDR_PROTECTION: begin
          next_cur.rdata[`PROT_ALLOW_BIT] = cur.allow_very_low_power;
        end
        `ADDR_STATUS: begin
          next_cur.rdata[5:0] = cur.mode;
        end
        default: begin
          next_cur.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
      next_cur.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // [RULE12] Reset to run, boot config applied next
      cur <= '0;
      cur.mode <= st_run;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign power_mode = cur.mode;

endmodule

/* File: tb/core_model.sv */
module core_model (
  input wire logic aclk,
  output logic sleep_request,
  output logic deep_sleep_flag,
  output logic interrupt_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sleep_request = 1'b0;
    deep_sleep_flag = 1'b0;
    interrupt_pending = 1'b0;
  end
  task automatic sleep(input logic deep);
    @(posedge aclk);
    deep_sleep_flag <= deep;
    sleep_request <= 1'b1;
    @(posedge aclk);
    sleep_request <= 1'b0;
  endtask
  // Gap lets the wake come promptly or late
  task automatic wake(input int gap);
    repeat (gap) @(posedge aclk);
    interrupt_pending <= 1'b1;
    @(posedge aclk);
    interrupt_pending <= 1'b0;
  endtask
endmodule

/* File: tb/power_mode_properties.sv */
module power_mode_checks
  import power_mode_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_request,
  input wire logic deep_sleep_flag,
  input wire logic interrupt_pending,
  input wire logic boot_power_config,
  input wire logic [5:0] power_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Interrupt excluded: with the wake bit set it outranks sleep in low-power run
  sequence light_s;
    sleep_request && !deep_sleep_flag && !interrupt_pending;
  endsequence
  sequence deep_s;
    sleep_request && deep_sleep_flag && !interrupt_pending;
  endsequence
  ////////////////////////////////////////////////////////////
  reset_run_a: assert property ($rose(aresetn) |-> power_mode == st_run)
    else $error("mode not run after reset");
  boot_vlp_a:
    assert property ($rose(aresetn) && boot_power_config |-> ##2 power_mode == st_very_low_power_run)
    else $error("boot config did not reach very_low_power_run");
  run_wait_a: assert property (power_mode == st_run ##0 light_s |=> power_mode == st_wait)
    else $error("run sleep not wait");
  run_stop_a:
    assert property (power_mode == st_run ##0 deep_s |=> power_mode inside {st_stop, st_very_low_power_stop})
    else $error("run deep sleep not stop");
  wake_run_a:
    assert property (power_mode inside {st_wait, st_stop} && interrupt_pending |=> power_mode == st_run)
    else $error("wait or stop wake not run");
  lp_wait_a: assert property (power_mode == st_very_low_power_run ##0 light_s |=> power_mode == st_very_low_power_wait)
    else $error("very_low_power_run sleep not very_low_power_wait");
  lp_wait_wake_a:
    assert property (power_mode == st_very_low_power_wait && interrupt_pending |=> power_mode inside {st_run, st_very_low_power_run})
    else $error("very_low_power_wait wake wrong");
  lp_stop_wake_a:
    assert property (power_mode == st_very_low_power_stop && interrupt_pending |=> power_mode inside {st_run, st_very_low_power_run})
    else $error("very_low_power_stop wake wrong");
  sleep_hold_a:
    assert property (power_mode inside {st_wait, st_stop, st_very_low_power_wait, st_very_low_power_stop} && !interrupt_pending
      |=> $stable(power_mode))
    else $error("sleep mode left without wake");
endmodule
bind power_mode_transition_fsm power_mode_checks checks (.*);

/* File: tb/power_mode_transition_fsm_test.sv */
module power_mode_transition_fsm_test
  import power_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, boot_power_config;
  logic sleep_request, deep_sleep_flag, interrupt_pending;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, lp_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] power_mode;
  logic [33:0] expq[$];
  logic [33:0] lpq[$];
  int n_errors = 0, n_checks = 0, cyc = 0;
  power_mode_transition_fsm uut (.*);
  // Same stimulus, built without the wake bit: its very-low-power wakes go to run only from a stop entered from run
  power_mode_transition_fsm #(.HAS_WAKE_TO_RUN(1'b0)) uut_fixed_wake (
    .*,
    .s_axi_awready(),
    .s_axi_wready(),
    .s_axi_bresp(),
    .s_axi_bvalid(),
    .s_axi_arready(),
    .s_axi_rdata(lp_rdata),
    .s_axi_rresp(),
    .s_axi_rvalid(),
    .power_mode()
  );
  core_model core (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [33:0] st(input mode_e m);
    return {28'h0, m};
  endfunction
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Upper data bits and strobes random: only the low byte and lane 0 may matter
  // Local flags, not the driven signals: those still hold old values in this step
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic lane0,
                    input logic [1:0] resp);
    logic [31:0] r;
    logic aw_done;
    logic w_done;
    logic b_done;
    r = $urandom();
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    expq.push_back({32'h0000_0000, resp});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {r[31:8], d};
    s_axi_wstrb <= {r[2:0], lane0};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_done) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b_done = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    logic ar_done;
    logic r_done;
    ar_done = 1'b0;
    r_done = 1'b0;
    expq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_done) begin
      @(posedge aclk);
      if (!ar_done && s_axi_arready) begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r_done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check("read resp and data", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
      if (lpq.size() > 0) check("fixed wake status", {2'h0, lp_rdata}, lpq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) check("write resp", {32'h0, s_axi_bresp}, expq.pop_front());
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    aresetn <= 1'b0;
    boot_power_config <= 1'b1;
    s_axi_awaddr <= 4'h0;
    s_axi_araddr <= 4'h0;
    s_axi_wstrb <= 4'hF;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    void'($urandom(32'h5D17));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(4'h8, st(st_very_low_power_run));
    rd(4'h4, 34'h20);
    core.sleep(1'b0);
    rd(4'h8, st(st_very_low_power_wait));
    core.wake($urandom_range(6));
    rd(4'h8, st(st_very_low_power_run));
    wr(4'h0, 8'hC0, 1'b1, 2'h0);
    core.sleep(1'b0);
    core.wake($urandom_range(6));
    lpq.push_back(st(st_very_low_power_run));
    rd(4'h8, st(st_run));
    rd(4'h0, 34'h80);
    $display("test low power wait done");
    wr(4'h0, 8'h00, 1'b1, 2'h0);
    core.sleep(1'b0);
    rd(4'h8, st(st_wait));
    core.wake(0);
    core.sleep(1'b1);
    rd(4'h8, st(st_stop));
    core.wake($urandom_range(6));
    rd(4'h8, st(st_run));
    $display("test normal modes done");
    wr(4'h0, 8'h40, 1'b1, 2'h0);
    core.sleep(1'b1);
    rd(4'h8, st(st_very_low_power_stop));
    core.wake($urandom_range(6));
    rd(4'h8, st(st_very_low_power_run));
    wr(4'h0, 8'h00, 1'b1, 2'h0);
    rd(4'h8, st(st_run));
    wr(4'h0, 8'hC0, 1'b1, 2'h0);
    core.wake(1);
    rd(4'h8, st(st_run));
    wr(4'h0, 8'h02, 1'b1, 2'h0);
    core.sleep(1'b1);
    core.wake($urandom_range(6));
    lpq.push_back(st(st_run));
    rd(4'h8, st(st_run));
    rd(4'hC, 34'h200000000);
    $display("test low power stop done");
    // Reset taken from a sleep mode, this time with the boot config clear
    core.sleep(1'b0);
    rd(4'h8, st(st_wait));
    aresetn <= 1'b0;
    boot_power_config <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h8, st(st_run));
    rd(4'h4, 34'h0);
    wr(4'h0, 8'h40, 1'b0, 2'h0);
    rd(4'h0, 34'h0);
    wr(4'h8, 8'h3F, 1'b1, 2'h0);
    wr(4'hC, 8'h40, 1'b1, 2'h2);
    rd(4'h8, st(st_run));
    $display("test reset recovery done");
    test_done();
  end
endmodule
